// file: hdl/maf_defs.svh
// Purpose: Constants for the multidrop serial address filter
// Assumes: Commands arrive already decoded, one strobe per command
// Notes on behaviour
// - First active interface after power wins.
// - Own address makes device addressed, accepts all.
// - Other address while addressed drops addressing.
// - Addresses span 0 through 30.
// - Address 31 is general unlist, not assignable.
// - Universal commands accepted while unaddressed.
// - Serial and parallel links share one address.
// - Collision may abort transfer, flush output buffer.
`ifndef MAF_DEFS_SVH
`define MAF_DEFS_SVH
`define MAF_ADDR_W 5
`define MAF_ADDR_UNL 5'h1f
`define MAF_ADDR_RST 5'h00
`endif

// file: hdl/maf_pkg.sv
// Purpose: Types for the address filter
// Assumes: Included defs give widths
// Notes: One-hot codes written out
`include "maf_defs.svh"
package maf_pkg;
  typedef logic [`MAF_ADDR_W-1:0] maf_addr_t;
  typedef enum logic [2:0] {
    MAF_IF_NONE = 3'b001,
    MAF_IF_SER = 3'b010,
    MAF_IF_PAR = 3'b100
  } maf_owner_t;
  typedef enum logic [1:0] {
    MAF_IDLE = 2'b01,
    MAF_LISTEN = 2'b10
  } maf_listen_t;
endpackage

// file: hdl/maf_arb_if.sv
// Purpose: Carries interface ownership between filter modules
// Assumes: One clock domain
// Notes: Arbiter drives, filter reads
`timescale 1ns/1ps
interface maf_arb_if;
  import maf_pkg::*;
  logic ser_grant;
  logic par_grant;
  modport arb (output ser_grant, output par_grant);
  modport use_side (input ser_grant, input par_grant);
endinterface

// file: hdl/maf_if_arbiter.sv
// Purpose: Grants remote control to the first active interface
// Assumes: Activity inputs are synchronous pulses
// Notes: Grant held until reset (power cycle)
`timescale 1ns/1ps
module maf_if_arbiter
  import maf_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ser_act,
  input wire logic par_act,
  maf_arb_if.arb arb
);
  import maf_pkg::*;
  maf_owner_t owner;
  maf_owner_t next_owner;

  always_comb
  begin
    next_owner = owner;
    unique case (owner)
      MAF_IF_NONE:
      begin
        // Serial wins a same-cycle tie
        if (ser_act)
          next_owner = MAF_IF_SER;
        else if (par_act)
          next_owner = MAF_IF_PAR;
      end
      MAF_IF_SER: next_owner = MAF_IF_SER;
      MAF_IF_PAR: next_owner = MAF_IF_PAR;
      default: next_owner = MAF_IF_NONE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      owner <= MAF_IF_NONE;
    else
      owner <= next_owner;
  end

  assign arb.ser_grant = (owner == MAF_IF_SER) || ((owner == MAF_IF_NONE) && ser_act);
  assign arb.par_grant = (owner == MAF_IF_PAR) ||
    ((owner == MAF_IF_NONE) && par_act && !ser_act);
endmodule

// file: hdl/maf_filter.sv
// Purpose: Address selection and command gating for the serial link
// Assumes: Byte framing and command parsing done upstream
// Notes: dev_addr shared with the parallel interface
`timescale 1ns/1ps
`include "maf_defs.svh"
module maf_filter
  import maf_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire maf_pkg::maf_addr_t dev_addr,
  input wire logic ser_act,
  input wire logic par_act,
  input wire logic cmd_addr,
  input wire maf_pkg::maf_addr_t cmd_addr_val,
  input wire logic cmd_univ,
  input wire logic cmd_other,
  input wire logic collision,
  output logic ser_en,
  output logic par_en,
  output logic addressed,
  output logic univ_exec,
  output logic other_exec,
  output logic flush_out
);
  import maf_pkg::*;
  maf_listen_t state;
  maf_listen_t next_state;
  logic next_univ;
  logic next_other;
  logic next_flush;
  logic own_hit;
  maf_arb_if arb_bus();

  maf_if_arbiter u_arb (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ser_act(ser_act),
    .par_act(par_act),
    .arb(arb_bus.arb)
  );

  // Unlist code never matches an own address
  function automatic logic addr_match(input maf_addr_t a, input maf_addr_t own);
    addr_match = (a == own) && (own != `MAF_ADDR_UNL);
  endfunction

  always_comb
  begin
    own_hit = addr_match(cmd_addr_val, dev_addr);
    next_state = state;
    next_univ = 1'b0;
    next_other = 1'b0;
    next_flush = 1'b0;
    if (arb_bus.ser_grant)
    begin
      if (cmd_addr)
      begin
        next_univ = 1'b1;
        if (own_hit)
          next_state = MAF_LISTEN;
        else
          next_state = MAF_IDLE;
      end
      else if (cmd_univ)
        next_univ = 1'b1;
      else if (cmd_other && state == MAF_LISTEN)
        next_other = 1'b1;
      if (collision && state == MAF_LISTEN)
        next_flush = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state <= MAF_IDLE;
      univ_exec <= 1'b0;
      other_exec <= 1'b0;
      flush_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      univ_exec <= next_univ;
      other_exec <= next_other;
      flush_out <= next_flush;
    end
  end

  assign addressed = (state == MAF_LISTEN);
  assign ser_en = arb_bus.ser_grant;
  assign par_en = arb_bus.par_grant;
endmodule

// file: dv/maf_filter_chk.sv
// Purpose: Port assertions for the filter
// Assumes: One clock, sync reset
// Notes: Bound below
`timescale 1ns/1ps
module maf_filter_chk
  import maf_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire maf_pkg::maf_addr_t dev_addr,
  input wire logic cmd_addr,
  input wire maf_pkg::maf_addr_t cmd_addr_val,
  input wire logic cmd_univ,
  input wire logic collision,
  input wire logic ser_en,
  input wire logic par_en,
  input wire logic addressed,
  input wire logic univ_exec,
  input wire logic other_exec,
  input wire logic flush_out
);
  import maf_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_one_owner: assert property (!(ser_en && par_en)) else $error("two owners");
  a_grant_kept: assert property (ser_en |=> ser_en) else $error("ser lost");
  a_par_kept: assert property (par_en |=> par_en) else $error("par lost");
  a_own_listen: assert property (ser_en && cmd_addr && cmd_addr_val == dev_addr
    && !(&dev_addr) |=> addressed) else $error("own addr missed");
  a_other_drop: assert property (ser_en && cmd_addr && cmd_addr_val != dev_addr
    |=> !addressed) else $error("not unlisted");
  a_unl_drop: assert property (ser_en && cmd_addr && (&cmd_addr_val) |=> !addressed)
    else $error("unlist missed");
  a_univ_taken: assert property (ser_en && (cmd_addr || cmd_univ) |=> univ_exec)
    else $error("univ missed");
  a_idle_ignore: assert property (!addressed |=> !other_exec) else $error("idle exec");
  a_flush_cause: assert property (flush_out |-> $past(collision) && $past(addressed))
    else $error("bad flush");
endmodule
bind maf_filter maf_filter_chk u_chk (.*);

// file: dv/maf_host.sv
// Purpose: Host model issuing commands
// Assumes: One command per cycle
// Notes: Drives at falling edge
`timescale 1ns/1ps
module maf_host
  import maf_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_addr = 1'h0,
  output maf_pkg::maf_addr_t cmd_addr_val = 5'h00,
  output logic cmd_univ = 1'h0,
  output logic cmd_other = 1'h0
);
  task automatic send(int k, maf_addr_t v);
    cmd_addr = k == 0;
    cmd_addr_val = v;
    cmd_univ = k == 1;
    cmd_other = k == 2;
    @(negedge core_clk);
  endtask
endmodule

// file: dv/maf_filter_tb.sv
// Purpose: Bench for the filter
// Assumes: Host model drives commands
// Notes: Pulses scored in issue order
`timescale 1ns/1ps
module maf_filter_tb;
  import maf_pkg::*;
  logic core_clk = 0, sys_rst = 1, ser_act = 0, par_act = 0, collision = 0, listen = 0;
  logic cmd_addr, cmd_univ, cmd_other, ser_en, par_en, addressed;
  logic univ_exec, other_exec, flush_out, was;
  maf_addr_t dev_addr = 5'h00, cmd_addr_val, v;
  logic [5:0] notes[$];
  logic [5:0] note, want;
  int failures = 0, comparisons = 0, cycles = 0, seed = 32'hf601, k;
  initial forever #12.5 core_clk = ~core_clk;
  maf_host u_host (.*);
  maf_filter u_dut (.*);
  task automatic check(logic [5:0] seen, logic [5:0] want);
    comparisons++;
    if (seen !== want)
    begin
      failures++;
      $display("mismatch outputs expected %h seen %h", want, seen);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
    if (univ_exec | other_exec | flush_out)
    begin
      want = notes.size() ? notes.pop_front() : 6'h00;
      check({ser_en, par_en, univ_exec, other_exec, flush_out, addressed}, want);
    end
  end
  initial
  begin
    dev_addr = 5'($unsigned($random(seed)) % 31);
    repeat (6) @(negedge core_clk);
    sys_rst = 0;
    ser_act = 1;
    for (int i = 0; i < 300; i++)
    begin
      k = $unsigned($random(seed)) % 3;
      v = i[0] ? dev_addr : 5'($random(seed));
      {par_act, collision} = 2'($random(seed));
      was = listen;
      if (k == 0)
        listen = v == dev_addr;
      note = {2'b10, k < 2, k == 2 && was, collision && was, listen};
      if (note[3:1] != 3'h0)
        notes.push_back(note);
      u_host.send(k, v);
    end
    u_host.send(3, v);
    check({5'h00, notes.size() != 0}, 6'h00);
    // Second power cycle, parallel link active first
    sys_rst = 1;
    {ser_act, par_act, collision} = 3'h0;
    listen = 0;
    repeat (2) @(negedge core_clk);
    sys_rst = 0;
    par_act = 1;
    @(negedge core_clk);
    ser_act = 1;
    for (int i = 0; i < 20; i++)
    begin
      collision = 1'($random(seed));
      u_host.send(i % 3, dev_addr);
      check({ser_en, par_en, 3'h0, addressed}, 6'h10);
    end
    wrap_up();
  end
endmodule
